// ---- include/erb_pkg.sv ----
// shared constants and carrier types of the embedded ram block
// assumes a single clock domain; sizes and modes are fixed at elaboration
package erb_pkg;

   // block sizes
   localparam logic [1:0] ERB_SIZE_SMALL  = 2'h0;
   localparam logic [1:0] ERB_SIZE_MEDIUM = 2'h1;
   localparam logic [1:0] ERB_SIZE_LARGE  = 2'h2;

   // native organisation of each size, parity bits included
   localparam int ERB_SMALL_DEPTH  = 32;
   localparam int ERB_SMALL_WIDTH  = 18;
   localparam int ERB_MEDIUM_DEPTH = 128;
   localparam int ERB_MEDIUM_WIDTH = 36;
   localparam int ERB_LARGE_DEPTH  = 4096;
   localparam int ERB_LARGE_WIDTH  = 144;

   // memory modes
   localparam logic [2:0] ERB_MODE_SP     = 3'h0;
   localparam logic [2:0] ERB_MODE_SDP    = 3'h1;
   localparam logic [2:0] ERB_MODE_TDP    = 3'h2;
   localparam logic [2:0] ERB_MODE_ROM    = 3'h3;
   localparam logic [2:0] ERB_MODE_TWO_SP = 3'h4;

   // byte lane widths with and without parity
   localparam int ERB_BYTE_PLAIN  = 8;
   localparam int ERB_BYTE_PARITY = 9;

   // reset and clear value of every input and output register
   localparam logic ERB_CLR_VAL = 1'b0;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
   } erb_ctl_t;

   function automatic int erb_cap(input logic [1:0] size);
      if (size == ERB_SIZE_SMALL) begin
         return ERB_SMALL_DEPTH * ERB_SMALL_WIDTH;
      end else if (size == ERB_SIZE_MEDIUM) begin
         return ERB_MEDIUM_DEPTH * ERB_MEDIUM_WIDTH;
      end
      return ERB_LARGE_DEPTH * ERB_LARGE_WIDTH;
   endfunction

   function automatic int erb_byte_w(input int w);
      if (w < ERB_BYTE_PLAIN) begin
         return w;
      end else if (w % ERB_BYTE_PARITY == 0) begin
         return ERB_BYTE_PARITY;
      end
      return ERB_BYTE_PLAIN;
   endfunction

endpackage

// ---- hdl/erb_port_reg.sv ----
// input register stage of one memory port: address, data, byte enables, enables
// assumes inputs synchronous to clock; clr is an asynchronous clear, active high
`timescale 1ns/1ps
module erb_port_reg #(
   parameter int AW = 7,
   parameter int DW = 36,
   parameter int NB = 4
) (
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic              portEn,
   input  wire logic              clr,
   input  wire logic [AW-1:0]     addr,
   input  wire logic [DW-1:0]     din,
   input  wire logic [NB-1:0]     be,
   input  wire erb_pkg::erb_ctl_t ctlIn,
   output logic      [AW-1:0]     addrQ,
   output logic      [DW-1:0]     dinQ,
   output logic      [NB-1:0]     beQ,
   output erb_pkg::erb_ctl_t      ctlQ,
   output logic                   wrStrobe
);
   import erb_pkg::*;

   logic     [AW-1:0] next_addrQ;
   logic     [DW-1:0] next_dinQ;
   logic     [NB-1:0] next_beQ;
   erb_ctl_t          next_ctlQ;

   // an idle port issues no operation but keeps its last address and data
   always_comb begin
      next_addrQ = portEn ? addr : addrQ;
      next_dinQ  = portEn ? din : dinQ;
      next_beQ   = portEn ? be : beQ;
      next_ctlQ  = portEn ? ctlIn : erb_ctl_t'{wrEn: 1'b0, rdEn: 1'b0};
   end

   always_ff @(posedge clock or posedge clr) begin
      if (clr) begin
         addrQ <= {AW{ERB_CLR_VAL}};
         dinQ  <= {DW{ERB_CLR_VAL}};
         beQ   <= {NB{ERB_CLR_VAL}};
         ctlQ  <= '{wrEn: ERB_CLR_VAL, rdEn: ERB_CLR_VAL};
      end else if (!resetn) begin
         addrQ <= {AW{ERB_CLR_VAL}};
         dinQ  <= {DW{ERB_CLR_VAL}};
         beQ   <= {NB{ERB_CLR_VAL}};
         ctlQ  <= '{wrEn: ERB_CLR_VAL, rdEn: ERB_CLR_VAL};
      end else if (ce) begin
         addrQ <= next_addrQ; // RL7
         dinQ  <= next_dinQ;
         beQ   <= next_beQ;
         ctlQ  <= next_ctlQ;
      end
   end

   // one strobe per captured write, timed by the clock, not by the user
   assign wrStrobe = ctlQ.wrEn; // RL8

endmodule

// ---- hdl/erb_ram_block.sv ----
// configurable synchronous embedded ram block with two ports
// assumes the user logic keeps depth times width within the chosen size
//
// Function
// [RL1] three sizes: 32x18, 128x36, 4Kx144, each with several aspect ratios
// [RL2] true dual-port only on medium and large; small falls back to simple dual-port
// [RL3] true dual-port takes any two reads or writes per cycle, ports paced independently; here both ports share one clock and one ce
// [RL4] simple dual-port read colliding with write gives old data or don't-care bits
// [RL5] single-port: separate read and write cycles; written data shows on output
// [RL6] the two ports may have different widths over the same storage
// [RL7] all inputs are captured in input registers on the clock edge
// [RL8] write strobe is generated internally from the clock
// [RL9] optional output register; bypass removes one pipeline cycle
// [RL10] small and medium simple dual-port allow flow-through reads on falling edge
// [RL11] medium block may hold two single-port memories of half capacity each
// [RL12] input clear on small and medium only; output clear on all sizes
// [RL13] large block has no preload; rom via writing once then write disable
// [RL14] input clear shows at next edge; output clear shows at once; input clear here is asynchronous and shows at once too
// [RL15] parity bit per byte stored; byte enables on medium and large
// [RL16] user keeps depth times width within the block capacity
`timescale 1ns/1ps
module erb_ram_block #(
   parameter logic [1:0]   SIZE      = erb_pkg::ERB_SIZE_MEDIUM,
   parameter logic [2:0]   MODE      = erb_pkg::ERB_MODE_TDP,
   parameter int           WA        = 36,
   parameter int           WB        = 36,
   parameter bit           OUT_REG_A = 1'b1,
   parameter bit           OUT_REG_B = 1'b1,
   parameter bit           RDW_OLD   = 1'b1,
   parameter bit           FLOW      = 1'b0,
   parameter logic [143:0] INIT_FILL = 144'h0,
   localparam int          AWA       = $clog2(erb_pkg::erb_cap(SIZE) / WA),
   localparam int          AWB       = $clog2(erb_pkg::erb_cap(SIZE) / WB),
   localparam int          NBA       = WA / erb_pkg::erb_byte_w(WA),
   localparam int          NBB       = WB / erb_pkg::erb_byte_w(WB)
) (
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              ce,
   input  wire logic              inClr,
   input  wire logic              outClr,
   input  wire logic              portEnA,
   input  wire logic [AWA-1:0]    addrA,
   input  wire logic [WA-1:0]     dinA,
   input  wire logic [NBA-1:0]    beA,
   input  wire erb_pkg::erb_ctl_t ctlA,
   output logic      [WA-1:0]     qA,
   input  wire logic              portEnB,
   input  wire logic [AWB-1:0]    addrB,
   input  wire logic [WB-1:0]     dinB,
   input  wire logic [NBB-1:0]    beB,
   input  wire erb_pkg::erb_ctl_t ctlB,
   output logic      [WB-1:0]     qB
);
   import erb_pkg::*;

   localparam int UW  = (WA < WB) ? WA : WB;
   localparam int KA  = WA / UW;
   localparam int KB  = WB / UW;
   localparam int DU  = erb_cap(SIZE) / UW; // RL1
   localparam int BYA = erb_byte_w(WA);
   localparam int BYB = erb_byte_w(WB);
   // small blocks cannot run true dual-port; only medium splits into two single ports
   localparam logic [2:0] EMODE = (SIZE == ERB_SIZE_SMALL && MODE == ERB_MODE_TDP) ?
                                  ERB_MODE_SDP :
                                  (SIZE != ERB_SIZE_MEDIUM && MODE == ERB_MODE_TWO_SP) ?
                                  ERB_MODE_SP : MODE;
   localparam bit CAN_WR_A = (EMODE != ERB_MODE_ROM);
   localparam bit CAN_RD_A = (EMODE != ERB_MODE_SDP);
   localparam bit CAN_WR_B = (EMODE == ERB_MODE_TDP) || (EMODE == ERB_MODE_TWO_SP);
   localparam bit CAN_RD_B = (EMODE != ERB_MODE_SP);
   localparam bit SP_LIKE  = (EMODE == ERB_MODE_SP) || (EMODE == ERB_MODE_TWO_SP);
   localparam bit HAS_INCLR = (SIZE != ERB_SIZE_LARGE);
   localparam bit OLD_DATA  = RDW_OLD && (SIZE != ERB_SIZE_LARGE);
   localparam bit FLOW_EFF  = FLOW && (SIZE != ERB_SIZE_LARGE) && (EMODE == ERB_MODE_SDP);
   localparam int BASE_B    = (EMODE == ERB_MODE_TWO_SP) ? DU / 2 : 0;

   logic [UW-1:0] mem [DU];

   logic              inClrEff;
   logic [AWA-1:0]    addrAQ;
   logic [WA-1:0]     dinAQ;
   logic [NBA-1:0]    beAQ;
   erb_ctl_t          ctlAQ;
   logic              strobeA;
   logic [AWB-1:0]    addrBQ;
   logic [WB-1:0]     dinBQ;
   logic [NBB-1:0]    beBQ;
   erb_ctl_t          ctlBQ;
   logic              strobeB;

   logic              wrA;
   logic              rdA;
   logic              wrB;
   logic              rdB;
   int                idxA;
   int                idxB;
   logic              overlap;
   logic [WA-1:0]     maskA;
   logic [WB-1:0]     maskB;
   logic [WA-1:0]     wordA;
   logic [WB-1:0]     wordB;
   logic [WB-1:0]     wordF;

   logic [WA-1:0]     rdLatchA;
   logic [WB-1:0]     rdLatchB;
   logic [WA-1:0]     outRegA;
   logic [WB-1:0]     outRegB;
   logic [WA-1:0]     next_rdLatchA;
   logic [WB-1:0]     next_rdLatchB;
   logic [AWB-1:0]    addrBN;
   logic [AWB-1:0]    next_addrBN;

   // the large block has no input clear; its input registers ignore the pin
   assign inClrEff = HAS_INCLR ? inClr : 1'b0; // RL12

   erb_port_reg #(.AW(AWA), .DW(WA), .NB(NBA)) portA (
      .clock    (clock),
      .resetn   (resetn),
      .ce       (ce),
      .portEn   (portEnA),
      .clr      (inClrEff),
      .addr     (addrA),
      .din      (dinA),
      .be       (beA),
      .ctlIn    (ctlA),
      .addrQ    (addrAQ),
      .dinQ     (dinAQ),
      .beQ      (beAQ),
      .ctlQ     (ctlAQ),
      .wrStrobe (strobeA)
   );

   erb_port_reg #(.AW(AWB), .DW(WB), .NB(NBB)) portB (
      .clock    (clock),
      .resetn   (resetn),
      .ce       (ce),
      .portEn   (portEnB),
      .clr      (inClrEff),
      .addr     (addrB),
      .din      (dinB),
      .be       (beB),
      .ctlIn    (ctlB),
      .addrQ    (addrBQ),
      .dinQ     (dinBQ),
      .beQ      (beBQ),
      .ctlQ     (ctlBQ),
      .wrStrobe (strobeB)
   );

   // in single-port modes a port with both enables high writes and drops the read
   assign wrA = strobeA && CAN_WR_A; // RL13
   assign rdA = ctlAQ.rdEn && CAN_RD_A && !(SP_LIKE && wrA); // RL5
   assign wrB = strobeB && CAN_WR_B; // RL2
   assign rdB = ctlBQ.rdEn && CAN_RD_B && !FLOW_EFF && !(SP_LIKE && wrB); // RL3

   // word index in storage units; unequal widths share one bit array
   assign idxA = int'(addrAQ) * KA; // RL6
   assign idxB = BASE_B + int'(addrBQ) * KB; // RL11
   assign overlap = (idxA < idxB + KB) && (idxB < idxA + KA);

   // byte enables gate whole lanes, parity bit included; small has none
   always_comb begin
      maskA = '0;
      maskB = '0;
      for (int i = 0; i < WA; i++) begin
         maskA[i] = (SIZE == ERB_SIZE_SMALL) ? 1'b1 : beAQ[i / BYA]; // RL15
      end
      for (int i = 0; i < WB; i++) begin
         maskB[i] = (SIZE == ERB_SIZE_SMALL) ? 1'b1 : beBQ[i / BYB]; // RL15
      end
   end

   always_comb begin
      wordA = '0;
      wordB = '0;
      wordF = '0;
      for (int k = 0; k < KA; k++) begin
         wordA[k*UW +: UW] = mem[idxA + k];
      end
      for (int k = 0; k < KB; k++) begin
         wordB[k*UW +: UW] = mem[idxB + k];
         wordF[k*UW +: UW] = mem[int'(addrBN) * KB + k];
      end
   end

   // the large block powers up with unknown contents and takes no preload
   initial begin
      if (SIZE != ERB_SIZE_LARGE) begin
         for (int i = 0; i < DU; i++) begin
            mem[i] = INIT_FILL[UW-1:0]; // RL13
         end
      end
   end

   // port b is applied last, so it wins when both ports write the same unit
   always @(posedge clock) begin
      if (ce) begin
         for (int k = 0; k < KA; k++) begin
            for (int b = 0; b < UW; b++) begin
               if (wrA && maskA[k*UW + b]) begin
                  mem[idxA + k][b] <= dinAQ[k*UW + b]; // RL3
               end
            end
         end
         for (int k = 0; k < KB; k++) begin
            for (int b = 0; b < UW; b++) begin
               if (wrB && maskB[k*UW + b]) begin
                  mem[idxB + k][b] <= dinBQ[k*UW + b]; // RL3
               end
            end
         end
      end
   end

   // reads sample the array before this edge's write lands, hence old data;
   // the don't-care choice inverts it so tests cannot rely on it
   always_comb begin
      next_rdLatchA = rdLatchA;
      next_rdLatchB = rdLatchB;
      if (SP_LIKE && wrA) begin
         next_rdLatchA = dinAQ; // RL5
      end else if (rdA) begin
         next_rdLatchA = (wrB && overlap && !OLD_DATA) ? ~wordA : wordA; // RL4
      end
      if (SP_LIKE && wrB) begin
         next_rdLatchB = dinBQ; // RL5
      end else if (rdB) begin
         next_rdLatchB = (wrA && overlap && !OLD_DATA) ? ~wordB : wordB; // RL4
      end
   end

   always_ff @(posedge clock or posedge outClr) begin
      if (outClr) begin
         rdLatchA <= {WA{ERB_CLR_VAL}}; // RL14
         rdLatchB <= {WB{ERB_CLR_VAL}};
         outRegA  <= {WA{ERB_CLR_VAL}};
         outRegB  <= {WB{ERB_CLR_VAL}};
      end else if (!resetn) begin
         rdLatchA <= {WA{ERB_CLR_VAL}};
         rdLatchB <= {WB{ERB_CLR_VAL}};
         outRegA  <= {WA{ERB_CLR_VAL}};
         outRegB  <= {WB{ERB_CLR_VAL}};
      end else if (ce) begin
         rdLatchA <= next_rdLatchA;
         rdLatchB <= next_rdLatchB;
         outRegA  <= rdLatchA; // RL9
         outRegB  <= rdLatchB;
      end
   end

   // flow-through: read address taken half a cycle after the rising edge
   always_comb begin
      next_addrBN = (portEnB && ctlB.rdEn) ? addrB : addrBN;
   end

   always_ff @(negedge clock) begin
      if (!resetn) begin
         addrBN <= {AWB{ERB_CLR_VAL}};
      end else if (ce) begin
         addrBN <= next_addrBN; // RL10
      end
   end

   // flow-through output is not a register, so outClr is applied by gating
   assign qA = OUT_REG_A ? outRegA : rdLatchA; // RL9
   assign qB = FLOW_EFF ? (outClr ? '0 : wordF) : (OUT_REG_B ? outRegB : rdLatchB); // RL10

   a_input_capture: assert property (@(posedge clock) disable iff (!resetn || inClrEff) // RL7
      (ce && portEnA && !inClrEff) |=> (addrAQ == $past(addrA) && dinAQ == $past(dinA)))
      else $error("port a inputs not captured");

   a_strobe_from_enable: assert property (@(posedge clock) disable iff (!resetn) // RL8
      strobeA |-> $past(ctlA.wrEn && portEnA && ce) || ($past(!ce) && $past(strobeA)))
      else $error("write strobe without a captured enable");

   a_sp_write_shows: assert property (@(posedge clock) disable iff (!resetn) // RL5
      (SP_LIKE && wrA && ce && !outClr) |=> (rdLatchA == $past(dinAQ)))
      else $error("single-port write data not on output");

   a_outreg_delay: assert property (@(posedge clock) disable iff (!resetn || outClr) // RL9
      (OUT_REG_A && ce) |=> (qA == $past(rdLatchA)))
      else $error("output register not one cycle behind");

   a_read_old_data: assert property (@(posedge clock) disable iff (!resetn || outClr) // RL4
      (OLD_DATA && rdB && wrA && overlap && ce) |=> (rdLatchB == $past(wordB)))
      else $error("colliding read did not return old data");

   a_small_no_tdp: assert property (@(posedge clock) disable iff (!resetn) // RL2
      (SIZE == ERB_SIZE_SMALL) |-> !wrB)
      else $error("small block wrote through port b");

   a_rom_no_write: assert property (@(posedge clock) disable iff (!resetn) // RL13
      (EMODE == ERB_MODE_ROM) |-> !wrA && !wrB)
      else $error("write in rom mode");

   a_out_clear_now: assert property (@(posedge clock) disable iff (!resetn) // RL14
      outClr |-> (qA == '0) && (qB == '0))
      else $error("output clear not immediate");

   a_half_split: assert property (@(posedge clock) disable iff (!resetn) // RL11
      (EMODE == ERB_MODE_TWO_SP && (wrA || rdA)) |-> (idxA + KA <= DU / 2))
      else $error("port a left its half of the split block");

   a_read_after_write: assert property (@(posedge clock) disable iff (!resetn || outClr) // RL3
      (EMODE == ERB_MODE_TDP && wrA && !wrB && maskA == '1 && ce) ##1
      (rdA && idxA == $past(idxA) && !wrB && ce) |=> (rdLatchA == $past(dinAQ, 2)))
      else $error("true dual-port read missed prior write");

   c_dual_write: cover property (@(posedge clock) disable iff (!resetn) wrA && wrB);
   c_collision: cover property (@(posedge clock) disable iff (!resetn) rdB && wrA && overlap);
   c_sp_write_read: cover property (@(posedge clock) disable iff (!resetn) wrA ##1 rdA);
   c_out_clear: cover property (@(posedge clock) disable iff (!resetn) outClr ##1 !outClr);

endmodule

// ---- sim/erb_fabric_model.sv ----
// user-logic model that drives both ports of the ram block
// assumes cyc is called once per clock; it waits for the rising edge itself
`timescale 1ns/1ps
module erb_fabric_model #(
   parameter int AWA = 7,
   parameter int WA  = 36,
   parameter int NBA = 4,
   parameter int AWB = 8,
   parameter int WB  = 18,
   parameter int NBB = 2
) (
   input  wire logic              clock,
   output logic                   portEnA,
   output logic      [AWA-1:0]    addrA,
   output logic      [WA-1:0]     dinA,
   output logic      [NBA-1:0]    beA,
   output erb_pkg::erb_ctl_t      ctlA,
   output logic                   portEnB,
   output logic      [AWB-1:0]    addrB,
   output logic      [WB-1:0]     dinB,
   output logic      [NBB-1:0]    beB,
   output erb_pkg::erb_ctl_t      ctlB
);
   import erb_pkg::*;
   // widths are fixed by parameters so depth times width never exceeds the block
   initial begin
      portEnA = 1'h0;
      addrA   = '0;
      dinA    = '0;
      beA     = '0;
      ctlA    = '0;
      portEnB = 1'h0;
      addrB   = '0;
      dinB    = '0;
      beB     = '0;
      ctlB    = '0;
   end
   // lines of an idle port toggle, so a stale value cannot pass for a fresh one
   task automatic cyc(input logic aw, input logic ar, input logic [AWA-1:0] aa,
                      input logic [WA-1:0] ad, input logic [NBA-1:0] ab,
                      input logic bw, input logic br, input logic [AWB-1:0] ba,
                      input logic [WB-1:0] bd, input logic [NBB-1:0] bb);
      @(posedge clock);
      portEnA <= aw | ar;
      ctlA    <= '{wrEn: aw, rdEn: ar};
      addrA   <= (aw | ar) ? aa : ~addrA;
      dinA    <= aw ? ad : ~dinA;
      beA     <= aw ? ab : ~beA;
      portEnB <= bw | br;
      ctlB    <= '{wrEn: bw, rdEn: br};
      addrB   <= (bw | br) ? ba : ~addrB;
      dinB    <= bw ? bd : ~dinB;
      beB     <= bw ? bb : ~beB;
   endtask
endmodule

// ---- sim/erb_ram_block_test.sv ----
// bench: medium block, true dual-port, 36-bit port A registered, 18-bit port B bypassed
// assumes the fabric model drives the ports; a shadow memory of 18-bit units predicts reads
`timescale 1ns/1ps
module erb_ram_block_test;
   import erb_pkg::*;
   logic              clock;
   logic              resetn;
   logic              ce;
   logic              inClr;
   logic              outClr;
   logic              portEnA;
   logic [6:0]        addrA;
   logic [35:0]       dinA;
   logic [3:0]        beA;
   erb_ctl_t          ctlA;
   logic [35:0]       qA;
   logic              portEnB;
   logic [7:0]        addrB;
   logic [17:0]       dinB;
   logic [1:0]        beB;
   erb_ctl_t          ctlB;
   logic [17:0]       qB;
   logic [17:0]       mem [256];
   logic [35:0]       prevA;
   logic [6:0]        ra;
   logic [7:0]        rb;
   logic [17:0]       rdb;
   int                n_errors;
   int                compares;
   int                cycles;

   // the rest keep their defaults: 36-bit registered port A, old data on collision
   erb_ram_block #(.SIZE(ERB_SIZE_MEDIUM), .MODE(ERB_MODE_TDP), .WB(18), .OUT_REG_B(1'b0))
      dut (.clock(clock), .resetn(resetn), .ce(ce), .inClr(inClr),
      .outClr(outClr), .portEnA(portEnA), .addrA(addrA), .dinA(dinA), .beA(beA),
      .ctlA(ctlA), .qA(qA), .portEnB(portEnB), .addrB(addrB), .dinB(dinB), .beB(beB),
      .ctlB(ctlB), .qB(qB));

   // the model's default widths match the block set up above
   erb_fabric_model fab (
      .clock(clock), .portEnA(portEnA), .addrA(addrA), .dinA(dinA), .beA(beA),
      .ctlA(ctlA), .portEnB(portEnB), .addrB(addrB), .dinB(dinB), .beB(beB),
      .ctlB(ctlB));

   always #2 clock = ~clock;

   // ceiling leaves ample margin over the roughly 420 cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("[FAIL] %0t run did not complete", $time);
         finish_test();
      end
   end

   function automatic logic [35:0] expA(input logic [6:0] a);
      return {mem[{a, 1'h1}], mem[{a, 1'h0}]};
   endfunction

   // lanes are 9 bits; the low unit of a wide word holds lanes 0 and 1
   function automatic void putA(input logic [6:0] a, input logic [35:0] d, input logic [3:0] be);
      for (int k = 0; k < 4; k++) begin
         if (be[k]) mem[{a, k[1]}][(k % 2) * 9 +: 9] = d[k * 9 +: 9];
      end
   endfunction

   function automatic void putB(input logic [7:0] b, input logic [17:0] d, input logic [1:0] be);
      for (int k = 0; k < 2; k++) begin
         if (be[k]) mem[b][k * 9 +: 9] = d[k * 9 +: 9];
      end
   endfunction

   task automatic chkA(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t qA %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkB(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t qB %h expected %h", $time, got, exp);
      end
   endtask

   task automatic idle();
      fab.cyc(1'h0, 1'h0, 7'h0, 36'h0, 4'h0, 1'h0, 1'h0, 8'h0, 18'h0, 2'h0);
   endtask

   task automatic wr(input logic aw, input logic [6:0] a, input logic [35:0] d,
                     input logic [3:0] be, input logic bw, input logic [7:0] b,
                     input logic [17:0] e, input logic [1:0] bb);
      fab.cyc(aw, 1'h0, a, d, be, bw, 1'h0, b, e, bb);
      if (aw) putA(a, d, be);
      if (bw) putB(b, e, bb);
   endtask

   // both ports read in one cycle; A shows one edge later than bypassed B
   task automatic rd(input logic [6:0] a, input logic [7:0] b);
      logic [35:0] eA;
      logic [17:0] eB;
      eA = expA(a);
      eB = mem[b];
      fab.cyc(1'h0, 1'h1, a, 36'h0, 4'h0, 1'h0, 1'h1, b, 18'h0, 2'h0);
      idle();
      idle();
      #1;
      chkB(qB, eB);
      chkA(qA, prevA);
      idle();
      #1;
      chkA(qA, eA);
      prevA = eA;
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clock = 1'h0;
      resetn = 1'h0;
      ce = 1'h1;
      inClr = 1'h0;
      outClr = 1'h0;
      n_errors = 0;
      compares = 0;
      cycles = 0;
      prevA = '0;
      foreach (mem[i]) mem[i] = 18'h0;
      void'($urandom(53887));
      repeat (2) @(posedge clock);
      resetn <= 1'h1;
      #1;
      chkA(qA, 36'h0);
      chkB(qB, 18'h0);
      $display("test reset done");
      wr(1'h1, 7'h03, 36'h9_5A5A_5A5A, 4'hF, 1'h0, 8'h0, 18'h0, 2'h0);
      rd(7'h03, 8'h07);
      wr(1'h1, 7'h03, 36'h0, 4'h5, 1'h1, 8'h09, 18'h3_FFFF, 2'h2);
      rd(7'h03, 8'h09);
      rd(7'h04, 8'h06);
      $display("test lanes done");
      for (int i = 0; i < 60; i++) begin
         ra = 7'($urandom);
         rb = 8'($urandom);
         if (rb[7:1] == ra) rb = rb ^ 8'h02;
         wr(1'($urandom), ra, 36'({$urandom, $urandom}), 4'($urandom), 1'($urandom), rb,
            18'($urandom), 2'($urandom));
         rd(7'($urandom), 8'($urandom));
      end
      $display("test random done");
      ra = 7'h10;
      rdb = mem[{ra, 1'h0}];
      fab.cyc(1'h1, 1'h0, ra, 36'h1_2345_6789, 4'hF, 1'h0, 1'h1, {ra, 1'h0}, 18'h0, 2'h0);
      putA(ra, 36'h1_2345_6789, 4'hF);
      idle();
      idle();
      #1;
      chkB(qB, rdb);
      rd(ra, {ra, 1'h1});
      $display("test collision done");
      // clock enable low: the write must not be taken
      fab.cyc(1'h1, 1'h0, 7'h11, ~expA(7'h11), 4'hF, 1'h0, 1'h0, 8'h0, 18'h0, 2'h0);
      ce <= 1'h0;
      idle();
      ce <= 1'h1;
      rd(7'h11, 8'h22);
      // input clear after capture cancels the pending write
      fab.cyc(1'h1, 1'h0, 7'h12, ~expA(7'h12), 4'hF, 1'h0, 1'h0, 8'h0, 18'h0, 2'h0);
      idle();
      inClr <= 1'h1;
      idle();
      inClr <= 1'h0;
      rd(7'h12, 8'h25);
      wr(1'h1, 7'h13, 36'hF_FFFF_FFFF, 4'hF, 1'h0, 8'h0, 18'h0, 2'h0);
      rd(7'h13, 8'h27);
      idle();
      outClr <= 1'h1;
      #1;
      chkA(qA, 36'h0);
      chkB(qB, 18'h0);
      idle();
      outClr <= 1'h0;
      prevA = '0;
      $display("test clears done");
      // write enables stay low from here on: contents serve as a rom
      for (int i = 0; i < 20; i++) begin
         rd(7'($urandom), 8'($urandom));
      end
      $display("test rom done");
      finish_test();
   end
endmodule
